// File: rtl/wmh_pkg.sv
// Package for the wireless module host interface block: constants and carriers.
// Assumes a 50 MHz system clock and an SPI clock from the host up to 25 MHz.
package wmh_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned BOOT_MS = 300;
  localparam int unsigned BOOT_CYCLES = (CLK_HZ / 1000) * BOOT_MS;
  localparam int unsigned DIAG_BAUD = 115200;
  localparam int unsigned DIAG_DIV = CLK_HZ / DIAG_BAUD;
  localparam int unsigned BEACON_CYCLES = 5000000;
  localparam logic [7:0] TX_IDLE_BYTE = 8'h00;

  typedef enum logic [2:0] {
    WMH_PS_BOOT = 3'b000,
    WMH_PS_SLEEP = 3'b001,
    WMH_PS_CHECK = 3'b010,
    WMH_PS_FETCH = 3'b011,
    WMH_PS_ACTIVE = 3'b100,
    WMH_PS_STANDBY = 3'b101
  } wmh_pstate_t;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } wmh_byte_t;

  typedef struct packed {
    logic oe_n;
    logic out;
  } wmh_pin_t;
endpackage : wmh_pkg

// File: rtl/wmh_buf2.sv
// Two-entry valid/ready buffer for bytes.
// Assumes both sides on the same clock.
`timescale 1ns/1ns
module wmh_buf2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  initial if (DEPTH != 2) $error("wmh_buf2 supports DEPTH 2 only");
  logic [WIDTH-1:0] mem [DEPTH];
  logic [1:0] count;
  logic wptr;
  logic rptr;
  logic [1:0] next_count;
  logic next_wptr;
  logic next_rptr;
  logic push;
  logic pop;

  always_comb
  begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wptr = wptr ^ push;
    next_rptr = rptr ^ pop;
    next_count = count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      count <= 2'd0;
      wptr <= 1'b0;
      rptr <= 1'b0;
    end
    else
    begin
      count <= next_count;
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
    if (push)
      mem[wptr] <= in_data;
  end

  assign in_ready = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data = mem[rptr];
endmodule : wmh_buf2

// File: rtl/wmh_top.sv
// Host-facing digital interface: SPI slave, attention line, power control, diag serial.
// Assumes SPI clock as own domain; power, scan, select and diag pins asynchronous to clk, other pins on clk.
`timescale 1ns/1ns
// Notes on behaviour
// - No state survives power-down and the host re-initialises after wake-up; here host_data keeps its last byte unless rx_tog was set, then it loads 8'h00.
// - After reset the module boots and is ready for traffic after about 300 ms.
// - The open-drain attention line is pulled low while data waits for the host.
// - The attention line is released once the pending data has been sent to the host.
// - Mode 0 is served and input is captured on rising clock edges after select.
// - Every byte moves most significant bit first on both data lines.
// - The diagnostic serial pins form an asynchronous link at 115200 bit/s.
// - In sleep the module wakes at each beacon, fetches queued traffic and signals, else sleeps.
module wmh_top #(
  parameter int unsigned BOOT_CYCLES = wmh_pkg::BOOT_CYCLES,
  parameter int unsigned BEACON_CYCLES = wmh_pkg::BEACON_CYCLES
) (
  // System
  input wire logic clk,
  input wire logic srst,
  // Power and test control
  input wire logic power_down,
  input wire logic scan_enable,
  input wire logic scan_reset_in,
  input wire logic sleep_enable,
  output logic regulators_on,
  output logic ready,
  output logic scan_mode,
  output logic [2:0] power_state,
  // Data from the radio side
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic traffic_queued,
  // Bytes received from the host
  output logic host_valid,
  output logic [7:0] host_data,
  // SPI link
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso_out,
  output logic spi_miso_oe_n,
  // Attention line, open drain
  output logic attn_n_out,
  output logic attn_n_oe_n,
  // Diagnostic serial
  input wire logic diag_serial_in,
  output logic diag_serial_out
);
  initial if (BOOT_CYCLES < 1 || BEACON_CYCLES < 1) $error("wmh_top: counts must be positive");

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers into clk
  logic [1:0] pd_s, sen_s, srst_s, cs_s, drx_s;
  always_ff @(posedge clk)
  begin
    pd_s <= {pd_s[0], power_down};
    sen_s <= {sen_s[0], scan_enable};
    srst_s <= {srst_s[0], scan_reset_in};
    cs_s <= {cs_s[0], spi_cs_n};
    drx_s <= {drx_s[0], diag_serial_in};
  end
  logic pd;
  assign pd = pd_s[1];
  // Power-down wipes the same state as a reset; host_data keeps its value unless rx_tog was set, then it loads the cleared rx_byte
  logic lrst;
  assign lrst = srst || pd;

  ////////////////////////////////////////////////////////////////////////////////
  // Power state machine
  logic out_valid, out_ready;
  logic [7:0] out_data;
  wmh_pkg::wmh_pstate_t ps, next_ps;
  logic [31:0] tmr, next_tmr;
  always_comb
  begin
    next_ps = ps;
    next_tmr = tmr + 32'd1;
    unique case (ps)
      wmh_pkg::WMH_PS_BOOT:
        if (tmr >= BOOT_CYCLES - 1)
        begin
          next_ps = wmh_pkg::WMH_PS_ACTIVE;
          next_tmr = 32'd0;
        end
      wmh_pkg::WMH_PS_ACTIVE:
      begin
        next_tmr = 32'd0;
        if (sleep_enable && !out_valid && cs_s[1])
          next_ps = wmh_pkg::WMH_PS_SLEEP;
      end
      wmh_pkg::WMH_PS_SLEEP:
        if (!sleep_enable)
        begin
          next_ps = wmh_pkg::WMH_PS_ACTIVE;
          next_tmr = 32'd0;
        end
        else if (tmr >= BEACON_CYCLES - 1)
        begin
          next_ps = wmh_pkg::WMH_PS_CHECK;
          next_tmr = 32'd0;
        end
      wmh_pkg::WMH_PS_CHECK:
      begin
        next_tmr = 32'd0;
        next_ps = traffic_queued ? wmh_pkg::WMH_PS_FETCH : wmh_pkg::WMH_PS_SLEEP;
      end
      wmh_pkg::WMH_PS_FETCH:
      begin
        next_tmr = 32'd0;
        if (!traffic_queued)
          next_ps = wmh_pkg::WMH_PS_STANDBY;
      end
      wmh_pkg::WMH_PS_STANDBY:
      begin
        next_tmr = 32'd0;
        next_ps = wmh_pkg::WMH_PS_ACTIVE;
      end
      default:
        next_ps = wmh_pkg::WMH_PS_BOOT;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (lrst)
    begin
      ps <= wmh_pkg::WMH_PS_BOOT;
      tmr <= 32'd0;
    end
    else
    begin
      ps <= next_ps;
      tmr <= next_tmr;
    end
  end
  logic run;
  assign run = (ps == wmh_pkg::WMH_PS_ACTIVE) || (ps == wmh_pkg::WMH_PS_FETCH)
    || (ps == wmh_pkg::WMH_PS_STANDBY);
  logic sleeping;
  assign sleeping = (ps == wmh_pkg::WMH_PS_SLEEP) || (ps == wmh_pkg::WMH_PS_CHECK);

  ////////////////////////////////////////////////////////////////////////////////
  // Buffer from the radio side to the SPI transmitter
  logic buf_in_ready;
  // A high rx_ready always promises room, so a taken byte is never refused
  logic take;
  assign take = rx_valid && rx_ready;
  wmh_buf2 #(.WIDTH(8), .DEPTH(2)) u_buf (
    .clk(clk),
    .srst(lrst),
    .in_valid(take && (run || sleeping)),
    .in_ready(buf_in_ready),
    .in_data(rx_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // SPI domain: shift on spi_clk, framed by chip select
  logic [2:0] bcnt;
  logic [6:0] rsh;
  logic [7:0] rx_byte;
  logic rx_tog;
  logic [7:0] tx_hold;
  logic armed;
  always_ff @(posedge spi_clk or posedge spi_cs_n)
  begin
    if (spi_cs_n)
    begin
      bcnt <= 3'd0;
      rsh <= 7'd0;
    end
    else
    begin
      rsh <= {rsh[5:0], spi_mosi};
      bcnt <= bcnt + 3'd1;
    end
  end
  // Toggle marks each full byte; cleared with the rest of the state
  always_ff @(posedge spi_clk or posedge lrst)
  begin
    if (lrst)
    begin
      rx_byte <= 8'h00;
      rx_tog <= 1'b0;
    end
    else if (!spi_cs_n && bcnt == 3'd7)
    begin
      rx_byte <= {rsh, spi_mosi};
      rx_tog <= ~rx_tog;
    end
  end
  // Output bit index advances on falling edges; bit 7 stands from select fall
  logic [2:0] fcnt;
  always_ff @(negedge spi_clk or posedge spi_cs_n)
  begin
    if (spi_cs_n)
      fcnt <= 3'd0;
    else
      fcnt <= fcnt + 3'd1;
  end
  // Held byte changes only while select is high, so the link reads it as static;
  // the host must leave select high a few system clocks between frames
  logic [7:0] tx_byte;
  assign tx_byte = armed ? tx_hold : wmh_pkg::TX_IDLE_BYTE;

  ////////////////////////////////////////////////////////////////////////////////
  // Crossings between the domains
  logic [2:0] rxt_s;
  always_ff @(posedge clk)
  begin
    rxt_s <= {rxt_s[1:0], rx_tog};
  end
  logic new_rx;
  assign new_rx = rxt_s[2] != rxt_s[1];
  // Held byte is consumed by the next full byte exchanged; reloads between frames
  logic next_armed;
  always_comb
  begin
    next_armed = armed;
    if (armed && new_rx)
      next_armed = 1'b0;
    else if (!armed && out_valid && run && cs_s[1])
      next_armed = 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (lrst)
      armed <= 1'b0;
    else
      armed <= next_armed;
    if (!armed && next_armed)
      tx_hold <= out_data;
  end
  assign out_ready = armed && new_rx;

  ////////////////////////////////////////////////////////////////////////////////
  // Diagnostic serial transmitter echoes received host bytes
  logic [9:0] dsh, next_dsh;
  logic [3:0] dbits, next_dbits;
  logic [15:0] ddiv, next_ddiv;
  always_comb
  begin
    next_dsh = dsh;
    next_dbits = dbits;
    next_ddiv = ddiv;
    if (dbits == 4'd0)
    begin
      if (new_rx && !drx_s[1] == 1'b0)
      begin
        next_dsh = {1'b1, rx_byte, 1'b0};
        next_dbits = 4'd10;
        next_ddiv = 16'(wmh_pkg::DIAG_DIV - 1);
      end
    end
    else if (ddiv == 16'd0)
    begin
      next_dsh = {1'b1, dsh[9:1]};
      next_dbits = dbits - 4'd1;
      next_ddiv = 16'(wmh_pkg::DIAG_DIV - 1);
    end
    else
      next_ddiv = ddiv - 16'd1;
  end
  always_ff @(posedge clk)
  begin
    if (lrst)
    begin
      dsh <= 10'h3ff;
      dbits <= 4'd0;
      ddiv <= 16'd0;
    end
    else
    begin
      dsh <= next_dsh;
      dbits <= next_dbits;
      ddiv <= next_ddiv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge clk)
  begin
    regulators_on <= !pd;
    scan_mode <= sen_s[1] && srst_s[1] && !srst;
    ready <= run && !lrst;
    power_state <= ps;
    rx_ready <= !lrst && (run || sleeping)
      && !((!buf_in_ready || (out_valid && take)) && !out_ready);
    host_valid <= new_rx && !lrst;
    host_data <= new_rx ? rx_byte : host_data;
    attn_n_out <= 1'b0;
    attn_n_oe_n <= lrst || !(out_valid || armed);
    diag_serial_out <= lrst ? 1'b1 : dsh[0];
  end
  // SPI output pin in the SPI domain, released while deselected
  always_comb
  begin
    spi_miso_out = tx_byte[3'd7 - fcnt];
    spi_miso_oe_n = spi_cs_n;
  end
endmodule : wmh_top

// File: testbench/wmh_props_properties.sv
// Checker for the host interface block, bound to its top-level ports.
// Assumes everything is sampled on clk; serial pins are asynchronous.
`timescale 1ns/1ns
module wmh_props #(
  parameter int unsigned BOOT_CYCLES = 100
) (
  // System
  input wire logic clk,
  input wire logic srst,
  // Power and test
  input wire logic power_down,
  input wire logic scan_enable,
  input wire logic scan_reset_in,
  input wire logic regulators_on,
  input wire logic ready,
  input wire logic scan_mode,
  input wire logic [2:0] power_state,
  // Data paths
  input wire logic rx_ready,
  input wire logic host_valid,
  input wire logic spi_cs_n,
  input wire logic spi_miso_oe_n,
  input wire logic attn_n_out,
  input wire logic attn_n_oe_n,
  input wire logic diag_serial_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Cycles since reset release, saturating
  logic [31:0] cnt;
  always_ff @(posedge clk)
  begin
    if (srst)
      cnt <= 32'h0;
    else if (cnt < BOOT_CYCLES)
      cnt <= cnt + 32'h1;
  end
  property p_regs_on; (cnt > 32'h4 && !power_down)[*4] |-> regulators_on; endproperty
  a_regs_on: assert property (p_regs_on) else $error("regulators off");
  property p_pd_off;
    power_down[*4] |-> !regulators_on && !ready && attn_n_oe_n && diag_serial_out;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("state kept in power down");
  property p_boot; ready |-> cnt >= BOOT_CYCLES; endproperty
  a_boot: assert property (p_boot) else $error("ready too early");
  property p_rx_boot; (power_state == 3'h0)[*2] |-> !rx_ready; endproperty
  a_rx_boot: assert property (p_rx_boot) else $error("radio byte taken in boot");
  property p_attn_od; !attn_n_oe_n |-> !attn_n_out; endproperty
  a_attn_od: assert property (p_attn_od) else $error("attention not low");
  property p_host_pulse; host_valid |=> !host_valid; endproperty
  a_host_pulse: assert property (p_host_pulse) else $error("host byte pulse long");
  property p_scan_on; (cnt > 32'h4 && scan_enable && scan_reset_in)[*4] |-> scan_mode; endproperty
  a_scan_on: assert property (p_scan_on) else $error("scan mode missing");
  property p_miso_rel; spi_cs_n |-> spi_miso_oe_n; endproperty
  a_miso_rel: assert property (p_miso_rel) else $error("data out driven");
  c_host: cover property (host_valid);
  c_attn: cover property (!attn_n_oe_n);
  c_scan: cover property (scan_mode);
endmodule : wmh_props
bind wmh_top wmh_props #(.BOOT_CYCLES(BOOT_CYCLES)) i_props (.clk(clk), .srst(srst),
  .power_down(power_down), .scan_enable(scan_enable), .scan_reset_in(scan_reset_in),
  .regulators_on(regulators_on), .ready(ready), .scan_mode(scan_mode),
  .power_state(power_state), .rx_ready(rx_ready),
  .host_valid(host_valid), .spi_cs_n(spi_cs_n), .spi_miso_oe_n(spi_miso_oe_n),
  .attn_n_out(attn_n_out), .attn_n_oe_n(attn_n_oe_n), .diag_serial_out(diag_serial_out));

// File: testbench/wmh_host_model.sv
// Host-side serial master model for the block's serial port.
// Assumes clock idle low; bit launched before each rising edge.
`timescale 1ns/1ns
module wmh_host_model (
  // Serial port
  output logic spi_clk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso_out,
  input wire logic spi_miso_oe_n
);
  initial
  begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // One byte each way; half period of at least 20 ns
  task automatic xfer(input logic [7:0] tx, input int half, output logic [7:0] rx);
    rx = 8'h00;
    #3 spi_cs_n = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      spi_mosi = tx[i];
      #half spi_clk = 1'b1;
      rx = {rx[6:0], spi_miso_oe_n ? 1'bx : spi_miso_out};
      #half spi_clk = 1'b0;
    end
    #half spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
  endtask : xfer
endmodule : wmh_host_model

// File: testbench/wmh_top_tb.sv
// Testbench for the host interface block.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ns
module wmh_top_tb;
  localparam int unsigned BOOT = 100;
  localparam int unsigned BEACON = 200;
  localparam int DIV = wmh_pkg::DIAG_DIV;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic power_down = 1'b0;
  logic scan_enable = 1'b0;
  logic scan_reset_in = 1'b0;
  logic sleep_enable = 1'b0;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic traffic_queued = 1'b0;
  logic regulators_on, ready, scan_mode, rx_ready, host_valid, attn_n_out, attn_n_oe_n;
  logic spi_clk, spi_cs_n, spi_mosi, spi_miso_out, spi_miso_oe_n, diag_serial_out;
  logic [2:0] power_state;
  logic [7:0] host_data, rd;
  logic seen_sleep = 1'b0;
  logic seen_fetch = 1'b0;
  logic [7:0] hq[$];
  int fail_count = 0;
  int n_tests = 0;
  int n;
  bit ok;
  wmh_top #(.BOOT_CYCLES(BOOT), .BEACON_CYCLES(BEACON)) i_dut (.clk(clk), .srst(srst),
    .power_down(power_down), .scan_enable(scan_enable), .scan_reset_in(scan_reset_in),
    .sleep_enable(sleep_enable), .regulators_on(regulators_on), .ready(ready),
    .scan_mode(scan_mode), .power_state(power_state), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .traffic_queued(traffic_queued),
    .host_valid(host_valid), .host_data(host_data), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso_out(spi_miso_out), .spi_miso_oe_n(spi_miso_oe_n),
    .attn_n_out(attn_n_out), .attn_n_oe_n(attn_n_oe_n), .diag_serial_in(1'b1),
    .diag_serial_out(diag_serial_out));
  wmh_host_model i_host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso_out(spi_miso_out), .spi_miso_oe_n(spi_miso_oe_n));
  initial
    forever #10 clk = ~clk;
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task stop_test;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  task cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  // Offers a radio byte and leaves valid up; ok when taken
  task push(input logic [7:0] d);
    rx_valid = 1'b1;
    rx_data = d;
    ok = 1'b0;
    for (int i = 0; i < 8 && !ok; i++)
    begin
      ok = (rx_ready === 1'b1);
      @(negedge clk);
    end
  endtask : push
  always @(negedge clk)
  begin
    if (host_valid === 1'b1)
      hq.push_back(host_data);
    if (power_state === wmh_pkg::WMH_PS_SLEEP)
      seen_sleep <= 1'b1;
    if (power_state === wmh_pkg::WMH_PS_FETCH)
      seen_fetch <= 1'b1;
  end
  initial
  begin
    cyc(20000);
    fail_count++;
    stop_test();
  end
  initial
  begin
    cyc(4);
    srst = 1'b0;
    cyc(BOOT - 10);
    check(ready, 1'b0);
    cyc(20);
    check(ready, 1'b1);
    check(regulators_on, 1'b1);
    check(attn_n_oe_n, 1'b1);
    check(spi_miso_oe_n, 1'b1);
    scan_enable = 1'b1;
    scan_reset_in = 1'b1;
    cyc(6);
    check(scan_mode, 1'b1);
    scan_reset_in = 1'b0;
    cyc(6);
    check(scan_mode, 1'b0);
    i_host.xfer(8'ha5, 20, rd);
    for (n = 0; n < 200 && diag_serial_out !== 1'b0; n++)
      @(negedge clk);
    cyc(DIV / 2);
    check(diag_serial_out, 8'h00);
    for (int i = 0; i < 9; i++)
    begin
      cyc(DIV);
      check(diag_serial_out, i < 8 ? (8'ha5 >> i) & 8'h01 : 8'h01);
    end
    i_host.xfer(8'h3c, 40, rd);
    cyc(8);
    check(8'(hq.size()), 8'h02);
    check(hq[0], 8'ha5);
    check(hq[1], 8'h3c);
    n = 0;
    ok = 1'b1;
    while (ok && n < 8)
    begin
      push(8'h10 + 8'(n));
      n = n + int'(ok);
    end
    rx_valid = 1'b0;
    check(n >= 2 && n < 8, 1'b1);
    check(attn_n_oe_n, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      cyc(8);
      i_host.xfer(8'h00, 20, rd);
      check(rd, 8'h10 + 8'(i));
    end
    cyc(8);
    check(attn_n_oe_n, 1'b1);
    sleep_enable = 1'b1;
    traffic_queued = 1'b1;
    cyc(3 * BEACON);
    check(seen_sleep, 1'b1);
    check(seen_fetch, 1'b1);
    sleep_enable = 1'b0;
    traffic_queued = 1'b0;
    push(8'h77);
    rx_valid = 1'b0;
    cyc(4);
    check(attn_n_oe_n, 1'b0);
    power_down = 1'b1;
    cyc(6);
    check(regulators_on, 1'b0);
    check(ready, 1'b0);
    check(attn_n_oe_n, 1'b1);
    power_down = 1'b0;
    cyc(BOOT + 20);
    check(ready, 1'b1);
    check(attn_n_oe_n, 1'b1);
    stop_test();
  end
endmodule : wmh_top_tb
